// [design/led_ctrl_regs.sv]
// Control and status register bank with its serial slave, all in one module.
// Assumes serial pins and cpu-side inputs are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_regs (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic osc_clk_i,
    input wire logic sync_i,
    input wire logic clock_missing_i,
    output logic sync_o,
    output logic sync_oe_o,
    output logic use_ext_clock_o,
    output logic osc_off_o,
    output logic device_active_o,
    output logic [3:0] master_rate_select_o,
    output logic led_shutdown_o,
    output led_ctrl_pkg::cpu_ctrl_t cpu_ctrl_o,
    output logic [7:0] job_code_a_o,
    output logic [7:0] job_code_b_o,
    input wire logic run_state_wr_i,
    input wire logic [7:0] run_state_data_i,
    input wire logic [6:0] irq_event_i,
    output logic irq_pin_n_o
);
    // Serial engine states, Gray steps along the usual path
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ADDR_ACK = 3'b011,
        S_WR_BYTE = 3'b010,
        S_WR_ACK = 3'b110,
        S_RD_BYTE = 3'b111,
        S_RD_ACK = 3'b101
    } ser_state_t;

    logic rst_meta_ff, rst_sync_ff; // Reset release stages
    logic rst_n; // Released reset
    logic clear; // Enable pin low wipes config
    ser_state_t state_ff; // Serial state
    logic scl_prev_ff, sda_prev_ff; // Last pin samples
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [3:0] bit_cnt_ff; // Bits moved this byte
    logic [7:0] shift_ff; // Serial shift register
    logic [7:0] ptr_ff; // Register pointer
    logic ptr_next_ff; // Next write byte is the pointer
    logic rw_ff; // Read request latched
    logic drive_low_ff; // Pulls data line low
    led_ctrl_pkg::reg_wr_t wr_ff; // Write strobe to registers
    logic rd_flags_ff; // Flag register was read out
    logic [7:0] rd_snap_ff; // Flags seen by that read
    logic [1:0] global_ff; // Active and osc bits
    led_ctrl_pkg::clock_cfg_t clk_cfg_ff; // Writable clock fields
    logic [1:0] cpu_bits_ff; // Reset release, clock gate
    logic wake_ff; // One-cycle wake pulse
    logic [7:0] job_a_ff, job_b_ff; // Job codes
    logic [7:0] run_state_ff; // Run state from cpu
    led_ctrl_pkg::irq_cfg_t irq_cfg_ff; // Pin style and width
    logic [7:0] irq_en_ff; // Per-source enables
    logic [7:0] irq_flags_ff; // Sticky flags
    logic lost_prev_ff; // For loss edge
    logic clock_lost; // Loss indication
    logic [7:0] events; // All flag set sources
    logic pending, pending_prev_ff; // Enabled flag present
    logic [led_ctrl_pkg::PULSE_CNT_W-1:0] pulse_cnt_ff; // Pulse countdown

    // Byte presented to the host for a given offset
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        case (a)
            led_ctrl_pkg::OFS_GLOBAL: read_mux = {6'h00, global_ff};
            led_ctrl_pkg::OFS_CLOCK_CFG: read_mux = {clock_lost, clk_cfg_ff[6:0]};
            led_ctrl_pkg::OFS_CPU_CTRL: read_mux = {6'h00, cpu_bits_ff};
            led_ctrl_pkg::OFS_JOB_A: read_mux = job_a_ff;
            led_ctrl_pkg::OFS_JOB_B: read_mux = job_b_ff;
            led_ctrl_pkg::OFS_RUN_STATE: read_mux = run_state_ff;
            led_ctrl_pkg::OFS_IRQ_CFG: read_mux = irq_cfg_ff;
            led_ctrl_pkg::OFS_IRQ_EN: read_mux = irq_en_ff;
            led_ctrl_pkg::OFS_IRQ_FLAGS: read_mux = irq_flags_ff;
            default: read_mux = led_ctrl_pkg::REG_RESET;
        endcase
    endfunction

    // Write strobe aimed at one offset
    function automatic logic hit(input led_ctrl_pkg::reg_wr_t w, input logic [7:0] a);
        hit = w.stb && (w.addr == a);
    endfunction
    logic [7:0] rd_byte; // Byte under the pointer
    assign rd_byte = read_mux(ptr_ff);

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;
    assign clear = !en_i;

    // Pin edge detection; pins are already synchronous
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= scl_i;
            sda_prev_ff <= sda_i;
        end
    end
    assign scl_rise = scl_i && !scl_prev_ff;
    assign scl_fall = !scl_i && scl_prev_ff;
    assign start_cond = scl_i && scl_prev_ff && sda_prev_ff && !sda_i;
    assign stop_cond = scl_i && scl_prev_ff && !sda_prev_ff && sda_i;

    // Serial slave: address, pointer byte, then data with auto-increment.
    // Data changes only while the clock is low so the host never sees a false start.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            ptr_next_ff <= 1'b1;
            rw_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            wr_ff <= '0;
            rd_flags_ff <= 1'b0;
            rd_snap_ff <= 8'h00;
        end else begin
            wr_ff.stb <= 1'b0;
            rd_flags_ff <= 1'b0;
            if (start_cond) begin
                // Start or repeated start
                state_ff <= S_ADDR;
                bit_cnt_ff <= 4'h0;
                ptr_next_ff <= 1'b1;
                drive_low_ff <= 1'b0;
            end else if (stop_cond) begin
                state_ff <= S_IDLE;
                drive_low_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_ADDR, S_WR_BYTE: begin
                        // Shift in on rising clock
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_i};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == led_ctrl_pkg::BITS_PER_BYTE) begin
                            bit_cnt_ff <= 4'h0;
                            if (state_ff == S_ADDR) begin
                                // Acknowledge only our own address
                                if (shift_ff[7:1] == led_ctrl_pkg::DEV_ADDR) begin
                                    rw_ff <= shift_ff[0];
                                    drive_low_ff <= 1'b1;
                                    state_ff <= S_ADDR_ACK;
                                end else begin
                                    state_ff <= S_IDLE;
                                end
                            end else begin
                                drive_low_ff <= 1'b1;
                                state_ff <= S_WR_ACK;
                                if (ptr_next_ff) begin
                                    ptr_ff <= shift_ff;
                                    ptr_next_ff <= 1'b0;
                                end else begin
                                    wr_ff.stb <= 1'b1;
                                    wr_ff.addr <= ptr_ff;
                                    wr_ff.data <= shift_ff;
                                    ptr_ff <= ptr_ff + 8'h01;
                                end
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        // Release ack, then start reading or writing
                        if (scl_fall) begin
                            if (rw_ff) begin
                                shift_ff <= rd_byte;
                                drive_low_ff <= !rd_byte[7];
                                rd_flags_ff <= (ptr_ff == led_ctrl_pkg::OFS_IRQ_FLAGS);
                                rd_snap_ff <= irq_flags_ff;
                                ptr_ff <= ptr_ff + 8'h01;
                                bit_cnt_ff <= 4'h1;
                                state_ff <= S_RD_BYTE;
                            end else begin
                                drive_low_ff <= 1'b0;
                                state_ff <= S_WR_BYTE;
                            end
                        end
                    end
                    S_WR_ACK: begin
                        if (scl_fall) begin
                            drive_low_ff <= 1'b0;
                            state_ff <= S_WR_BYTE;
                        end
                    end
                    S_RD_BYTE: begin
                        // Shift out on falling clock
                        if (scl_fall) begin
                            if (bit_cnt_ff == led_ctrl_pkg::BITS_PER_BYTE) begin
                                drive_low_ff <= 1'b0;
                                state_ff <= S_RD_ACK;
                            end else begin
                                drive_low_ff <= !shift_ff[6];
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    S_RD_ACK: begin
                        // Host nack ends the read; ack loads the next byte
                        if (scl_rise && sda_i) begin
                            state_ff <= S_IDLE;
                        end else if (scl_fall) begin
                            shift_ff <= rd_byte;
                            drive_low_ff <= !rd_byte[7];
                            rd_flags_ff <= (ptr_ff == led_ctrl_pkg::OFS_IRQ_FLAGS);
                            rd_snap_ff <= irq_flags_ff;
                            ptr_ff <= ptr_ff + 8'h01;
                            bit_cnt_ff <= 4'h1;
                            state_ff <= S_RD_BYTE;
                        end
                    end
                    default: begin
                        state_ff <= S_IDLE;
                        drive_low_ff <= 1'b0;
                    end
                endcase
            end
        end
    end
    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_low_ff;

    // Global control
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            global_ff <= 2'h0;
        end else if (clear) begin
            global_ff <= 2'h0;
        end else if (hit(wr_ff, led_ctrl_pkg::OFS_GLOBAL)) begin
            global_ff <= wr_ff.data[1:0];
        end
    end
    assign osc_off_o = global_ff[led_ctrl_pkg::GLB_OSC_OFF_BIT];
    assign device_active_o = global_ff[led_ctrl_pkg::GLB_ACTIVE_BIT];

    // Clock configuration; top bit is status and ignores writes
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_cfg_ff <= '0;
        end else if (clear) begin
            clk_cfg_ff <= '0;
        end else if (hit(wr_ff, led_ctrl_pkg::OFS_CLOCK_CFG)) begin
            clk_cfg_ff <= {1'b0, wr_ff.data[6:0]};
        end
    end
    // Loss only means something with the external source
    assign use_ext_clock_o = clk_cfg_ff.clock_source_select[led_ctrl_pkg::SRC_EXT_BIT];
    assign clock_lost = use_ext_clock_o && clock_missing_i;
    assign led_shutdown_o = clock_lost && !clk_cfg_ff.clock_loss_guard_off;
    assign sync_oe_o = (clk_cfg_ff.clock_source_select == led_ctrl_pkg::SRC_OSC_DRIVE);
    assign sync_o = osc_clk_i;
    assign master_rate_select_o = clk_cfg_ff.master_rate_select;

    // Cpu control; wake is a write-one pulse and is not stored
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_bits_ff <= 2'h0;
            wake_ff <= 1'b0;
        end else if (clear) begin
            cpu_bits_ff <= 2'h0;
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= hit(wr_ff, led_ctrl_pkg::OFS_CPU_CTRL)
                && wr_ff.data[led_ctrl_pkg::CPU_WAKE_BIT];
            if (hit(wr_ff, led_ctrl_pkg::OFS_CPU_CTRL)) begin
                cpu_bits_ff <= wr_ff.data[1:0];
            end
        end
    end
    assign cpu_ctrl_o.cpu_wakeup = wake_ff;
    assign cpu_ctrl_o.cpu_reset_release = cpu_bits_ff[led_ctrl_pkg::CPU_RST_BIT];
    assign cpu_ctrl_o.cpu_clock_gate = cpu_bits_ff[led_ctrl_pkg::CPU_CLK_BIT];

    // Job codes; the host must load them before starting the cpu
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            job_a_ff <= led_ctrl_pkg::REG_RESET;
            job_b_ff <= led_ctrl_pkg::REG_RESET;
        end else if (clear) begin
            job_a_ff <= led_ctrl_pkg::REG_RESET;
            job_b_ff <= led_ctrl_pkg::REG_RESET;
        end else begin
            if (hit(wr_ff, led_ctrl_pkg::OFS_JOB_A)) begin
                job_a_ff <= wr_ff.data;
            end
            if (hit(wr_ff, led_ctrl_pkg::OFS_JOB_B)) begin
                job_b_ff <= wr_ff.data;
            end
        end
    end
    assign job_code_a_o = job_a_ff;
    assign job_code_b_o = job_b_ff;

    // Run state written only from the cpu side
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_state_ff <= led_ctrl_pkg::RUN_NONE;
        end else if (clear) begin
            run_state_ff <= led_ctrl_pkg::RUN_NONE;
        end else if (run_state_wr_i) begin
            run_state_ff <= run_state_data_i;
        end
    end

    // Interrupt configuration and enables
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_cfg_ff <= '0;
            irq_en_ff <= led_ctrl_pkg::REG_RESET;
        end else if (clear) begin
            irq_cfg_ff <= '0;
            irq_en_ff <= led_ctrl_pkg::REG_RESET;
        end else begin
            if (hit(wr_ff, led_ctrl_pkg::OFS_IRQ_CFG)) begin
                irq_cfg_ff <= wr_ff.data;
            end
            if (hit(wr_ff, led_ctrl_pkg::OFS_IRQ_EN)) begin
                irq_en_ff <= wr_ff.data;
            end
        end
    end

    // Sticky flags; cleared by reading them, but a new event wins
    assign events = {clock_lost && !lost_prev_ff, irq_event_i};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags_ff <= 8'h00;
            lost_prev_ff <= 1'b0;
        end else if (clear) begin
            irq_flags_ff <= 8'h00;
            lost_prev_ff <= 1'b0;
        end else begin
            lost_prev_ff <= clock_lost;
            irq_flags_ff <= (irq_flags_ff & ~(rd_flags_ff ? rd_snap_ff : 8'h00))
                | events;
        end
    end

    // Pin drive: level while pending, or one pulse per new pending
    assign pending = |(irq_flags_ff & irq_en_ff);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pending_prev_ff <= 1'b0;
            pulse_cnt_ff <= '0;
        end else begin
            pending_prev_ff <= pending;
            if (pending && !pending_prev_ff) begin
                // Width counts in fixed units; zero width gives no pulse
                pulse_cnt_ff <= led_ctrl_pkg::PULSE_CNT_W'(irq_cfg_ff.irq_pulse_width
                    * led_ctrl_pkg::PULSE_UNIT_CYC);
            end else if (pulse_cnt_ff != '0) begin
                pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
            end
        end
    end
    assign irq_pin_n_o = irq_cfg_ff.irq_pin_style ? (pulse_cnt_ff == '0) : !pending;
endmodule
`default_nettype wire

// [inc/led_ctrl_pkg.sv]
// Constants, register map and carrier types for the LED SoC control register bank.
// Assumes a single 250 MHz clock and a host that reaches the bank over the serial pins.
package led_ctrl_pkg;
    // Register offsets
    localparam logic [7:0] OFS_GLOBAL = 8'h02;
    localparam logic [7:0] OFS_CLOCK_CFG = 8'h03;
    localparam logic [7:0] OFS_CPU_CTRL = 8'h04;
    localparam logic [7:0] OFS_JOB_A = 8'h05;
    localparam logic [7:0] OFS_JOB_B = 8'h06;
    localparam logic [7:0] OFS_RUN_STATE = 8'h07;
    localparam logic [7:0] OFS_IRQ_CFG = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h09;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0A;
    // Common reset value and read value of unmapped bytes
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int GLB_OSC_OFF_BIT = 1;
    localparam int GLB_ACTIVE_BIT = 0;
    localparam int CPU_WAKE_BIT = 2;
    localparam int CPU_RST_BIT = 1;
    localparam int CPU_CLK_BIT = 0;
    localparam int IRQ_CLOCK_LOSS_BIT = 7;
    // Clock source codes (upper bit set means external)
    localparam logic [1:0] SRC_OSC_QUIET = 2'h0;
    localparam logic [1:0] SRC_OSC_DRIVE = 2'h1;
    localparam int SRC_EXT_BIT = 1;
    // Master rate codes
    localparam logic [3:0] RATE_24M576 = 4'h0;
    localparam logic [3:0] RATE_12M288 = 4'h1;
    localparam logic [3:0] RATE_8M192 = 4'h2;
    localparam logic [3:0] RATE_6M144 = 4'h3;
    // Run state codes written by the embedded cpu
    localparam logic [7:0] RUN_NONE = 8'h00;
    localparam logic [7:0] RUN_SLEEP = 8'h01;
    localparam logic [7:0] RUN_IDLE = 8'h02;
    localparam logic [7:0] RUN_BREATH = 8'h10;
    localparam logic [7:0] RUN_BREATH_DONE = 8'h11;
    localparam logic [7:0] RUN_AUDIO = 8'h20;
    // Interrupt pin pulse unit; figure is arbitrary
    localparam int PULSE_UNIT_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 16;
    // Serial slave address; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h35;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Clock configuration fields
    typedef struct packed {
        logic clock_lost_flag;
        logic clock_loss_guard_off;
        logic [1:0] clock_source_select;
        logic [3:0] master_rate_select;
    } clock_cfg_t;

    // Controls toward the embedded cpu
    typedef struct packed {
        logic cpu_wakeup;
        logic cpu_reset_release;
        logic cpu_clock_gate;
    } cpu_ctrl_t;

    // Interrupt configuration fields
    typedef struct packed {
        logic [6:0] irq_pulse_width;
        logic irq_pin_style;
    } irq_cfg_t;

    // One byte access from the serial engine
    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;
endpackage

// [verif/led_ctrl_regs_properties.sv]
// Port checker for the LED SoC register bank.
// Bound to led_ctrl_regs; one clock.
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_regs_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic osc_clk_i,
    input wire logic clock_missing_i,
    input wire logic sync_o,
    input wire logic sync_oe_o,
    input wire logic use_ext_clock_o,
    input wire logic osc_off_o,
    input wire logic device_active_o,
    input wire logic [3:0] master_rate_select_o,
    input wire logic led_shutdown_o,
    input wire led_ctrl_pkg::cpu_ctrl_t cpu_ctrl_o,
    input wire logic [7:0] job_code_a_o,
    input wire logic [7:0] job_code_b_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Wake is a one-cycle strobe
    sequence wake_high;
        cpu_ctrl_o.cpu_wakeup;
    endsequence
    sequence wake_low;
        !cpu_ctrl_o.cpu_wakeup;
    endsequence
    AST_WAKE_PULSE: assert property ($rose(cpu_ctrl_o.cpu_wakeup) |-> wake_high ##1 wake_low)
        else $error("wake too long");
    AST_SYNC_DRIVE: assert property (sync_oe_o |-> !use_ext_clock_o)
        else $error("sync drive");
    AST_SYNC_FOLLOW: assert property (sync_o == osc_clk_i)
        else $error("sync follow");
    AST_GUARD_EXT: assert property (!use_ext_clock_o |-> !led_shutdown_o)
        else $error("shutdown int");
    AST_GUARD_MISS: assert property (!clock_missing_i |-> !led_shutdown_o)
        else $error("shutdown clk");
    AST_EN_JOB: assert property (!en_i |=> job_code_a_o == 8'h00 && job_code_b_o == 8'h00)
        else $error("job clear");
    AST_EN_CPU: assert property (!en_i |=> cpu_ctrl_o == 3'h0)
        else $error("cpu clear");
    AST_EN_GLOBAL: assert property (!en_i |=> !osc_off_o && !device_active_o && master_rate_select_o == 4'h0)
        else $error("global clear");
endmodule
`default_nettype wire

// [verif/i2c_host_model.sv]
// Host serial master model for the register bank's two-wire port.
// Assumes a pull-up on the data line.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input wire logic clk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o,
    output logic rd_done_o,
    output logic [7:0] rd_data_o
);
    logic pull_low = 1'b0; // Host pulling the data line low
    initial begin
        scl_o = 1'b1;
        rd_done_o = 1'b0;
        rd_data_o = 8'h00;
    end
    // Released line floats high
    assign sda_o = !(pull_low || sda_oe_i);
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Data moves while clock is low
    task automatic bit_io(input logic b, output logic r);
        hold(2);
        pull_low = !b;
        hold(3);
        scl_o = 1'b1;
        hold(4);
        r = sda_o;
        scl_o = 1'b0;
    endtask
    // Start, or stop when to_idle
    task automatic edge_cond(input logic to_idle);
        hold(2);
        pull_low = to_idle;
        hold(3);
        scl_o = 1'b1;
        hold(4);
        pull_low = !to_idle;
        hold(4);
        scl_o = to_idle;
    endtask
    task automatic send(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
    endtask
    task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
        edge_cond(1'b0);
        send({led_ctrl_pkg::DEV_ADDR, 1'b0});
        send(ofs);
        send(d);
        edge_cond(1'b1);
    endtask
    // Pointer write, restart, one byte, nack
    task automatic reg_read(input logic [7:0] ofs);
        logic [7:0] v;
        logic r;
        edge_cond(1'b0);
        send({led_ctrl_pkg::DEV_ADDR, 1'b0});
        send(ofs);
        edge_cond(1'b0);
        send({led_ctrl_pkg::DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(1'b1, r);
        edge_cond(1'b1);
        rd_data_o = v;
        rd_done_o = 1'b1;
        hold(1);
        rd_done_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/led_ctrl_regs_bench.sv]
// Self-checking bench for the LED SoC register bank.
// Assumes the host model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_regs_bench;
    logic clk_i, arst_n_i = 1'b0, en_i = 1'b1, osc_clk_i = 1'b0, clock_missing_i = 1'b0;
    logic run_state_wr_i = 1'b0, scl, sda, sda_oe_o, rd_done, sync_o, sync_oe_o, use_ext_clock_o;
    logic osc_off_o, device_active_o, led_shutdown_o, irq_pin_n_o;
    logic [7:0] run_state_data_i = 8'h00, rd_data, job_code_a_o, job_code_b_o, a, b;
    logic [6:0] irq_event_i = 7'h00;
    logic [3:0] master_rate_select_o;
    led_ctrl_pkg::cpu_ctrl_t cpu_ctrl_o;
    logic [7:0] exp_q[$]; // Expected reads
    logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h20};
    int fails = 0, total_checks = 0, n;
    led_ctrl_regs u_led_ctrl_regs (.clk_i(clk_i), .arst_n_i(arst_n_i), .en_i(en_i), .scl_i(scl),
        .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o), .osc_clk_i(osc_clk_i), .sync_i(1'b0),
        .clock_missing_i(clock_missing_i), .sync_o(sync_o), .sync_oe_o(sync_oe_o),
        .use_ext_clock_o(use_ext_clock_o), .osc_off_o(osc_off_o), .device_active_o(device_active_o),
        .master_rate_select_o(master_rate_select_o), .led_shutdown_o(led_shutdown_o),
        .cpu_ctrl_o(cpu_ctrl_o), .job_code_a_o(job_code_a_o), .job_code_b_o(job_code_b_o),
        .run_state_wr_i(run_state_wr_i), .run_state_data_i(run_state_data_i),
        .irq_event_i(irq_event_i), .irq_pin_n_o(irq_pin_n_o));
    i2c_host_model u_i2c_host_model (.clk_i(clk_i), .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda),
        .rd_done_o(rd_done), .rd_data_o(rd_data));
    // Free-running clock, 4 ns period
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Oscillator stand-in
    always @(negedge clk_i) osc_clk_i <= ~osc_clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        u_i2c_host_model.reg_write(o, d);
    endtask
    // Queue the expectation
    task automatic rd(input logic [7:0] o, input logic [7:0] e);
        exp_q.push_back(e);
        u_i2c_host_model.reg_read(o);
    endtask
    task automatic ev(input logic [6:0] v);
        @(negedge clk_i) irq_event_i = v;
        @(negedge clk_i) irq_event_i = 7'h00;
    endtask
    // Read monitor
    always @(posedge clk_i) if (rd_done) chk(rd_data, exp_q.pop_front(), "read byte");
    task automatic test_done();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(97));
        repeat (4) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        for (int i = 2; i <= 11; i++) rd(8'(i), 8'h00);
        $display("reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(led_ctrl_pkg::OFS_CLOCK_CFG, 8'(k * 17));
            chk(sync_oe_o, 8'(k == 1), "sync drive");
            chk(use_ext_clock_o, 8'(k / 2), "ext source");
            chk({4'h0, master_rate_select_o}, 8'(k), "rate");
        end
        wr(led_ctrl_pkg::OFS_CLOCK_CFG, 8'hA0);
        rd(led_ctrl_pkg::OFS_CLOCK_CFG, 8'h20);
        @(negedge clk_i) clock_missing_i = 1'b1;
        @(negedge clk_i) chk(led_shutdown_o, 8'h01, "guard armed");
        rd(led_ctrl_pkg::OFS_CLOCK_CFG, 8'hA0);
        wr(led_ctrl_pkg::OFS_CLOCK_CFG, 8'h60);
        chk(led_shutdown_o, 8'h00, "guard off");
        rd(led_ctrl_pkg::OFS_IRQ_FLAGS, 8'h80);
        clock_missing_i = 1'b0;
        wr(led_ctrl_pkg::OFS_GLOBAL, 8'h03);
        chk({osc_off_o, device_active_o}, 8'h03, "global bits");
        rd(led_ctrl_pkg::OFS_GLOBAL, 8'h03);
        $display("clock and global done");
        a = 8'($urandom);
        b = 8'($urandom);
        wr(led_ctrl_pkg::OFS_JOB_A, a);
        wr(led_ctrl_pkg::OFS_JOB_B, b);
        wr(led_ctrl_pkg::OFS_CPU_CTRL, 8'h07);
        chk({5'h0, cpu_ctrl_o}, 8'h03, "cpu run");
        chk(job_code_a_o, a, "job a");
        chk(job_code_b_o, b, "job b");
        rd(led_ctrl_pkg::OFS_CPU_CTRL, 8'h03);
        rd(led_ctrl_pkg::OFS_JOB_A, a);
        rd(led_ctrl_pkg::OFS_JOB_B, b);
        wr(led_ctrl_pkg::OFS_CPU_CTRL, 8'h00);
        chk({5'h0, cpu_ctrl_o}, 8'h00, "cpu halt");
        foreach (codes[i]) begin
            @(negedge clk_i) run_state_data_i = codes[i];
            run_state_wr_i = 1'b1;
            @(negedge clk_i) run_state_wr_i = 1'b0;
            rd(led_ctrl_pkg::OFS_RUN_STATE, codes[i]);
        end
        wr(led_ctrl_pkg::OFS_RUN_STATE, 8'h5A);
        rd(led_ctrl_pkg::OFS_RUN_STATE, led_ctrl_pkg::RUN_AUDIO);
        $display("cpu and run state done");
        wr(led_ctrl_pkg::OFS_IRQ_EN, 8'h01);
        ev(7'h02);
        chk(irq_pin_n_o, 8'h01, "masked source");
        ev(7'h01);
        chk(irq_pin_n_o, 8'h00, "level pin");
        rd(led_ctrl_pkg::OFS_IRQ_FLAGS, 8'h03);
        chk(irq_pin_n_o, 8'h01, "pin after clear");
        wr(led_ctrl_pkg::OFS_IRQ_CFG, 8'h03);
        rd(led_ctrl_pkg::OFS_IRQ_CFG, 8'h03);
        ev(7'h01);
        n = 0;
        for (int i = 0; i < 1000; i++) @(negedge clk_i) n += int'(irq_pin_n_o === 1'b0);
        chk(8'(n / 10), 8'(led_ctrl_pkg::PULSE_UNIT_CYC / 10), "pulse width");
        $display("interrupt done");
        @(negedge clk_i) en_i = 1'b0;
        repeat (2) @(negedge clk_i);
        en_i = 1'b1;
        rd(led_ctrl_pkg::OFS_JOB_A, 8'h00);
        rd(led_ctrl_pkg::OFS_IRQ_EN, 8'h00);
        $display("enable clear done");
        test_done();
    end
endmodule
bind led_ctrl_regs led_ctrl_regs_properties u_led_ctrl_regs_properties (.*);
`default_nettype wire
